// ===== rtl/usw_serial_port.sv
// Serial port control: soft reset, transmit wake and a small transmitter
`timescale 1ns/1ps
module usw_serial_port
  import usw_pkg::*;
#(
   parameter int BIT_CYCLES = usw_pkg::BIT_CYCLES_DEF
)(
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [usw_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   input  wire logic                     rx_wake_evt,
   input  wire logic                     rx_parity_evt,
   input  wire logic                     rx_overrun_evt,
   input  wire logic                     rx_framing_evt,
   input  wire logic                     rx_break_evt,
   input  wire logic                     rx_ready_evt,
   output logic                          tx_line_o,
   output logic                          irq_o
);
   import usw_pkg::*;

   localparam int CW = $clog2(BIT_CYCLES + 1);
   localparam logic [CW-1:0] TICK_LAST = CW'(BIT_CYCLES - 1);

   function automatic logic hit(input logic [ADR_W-1:0] adr,
                                input logic [7:0]       off);
      hit = (adr == off);
   endfunction

   logic                 req;
   logic                 wr;
   logic                 wr_ccr;
   logic                 wr_ctl1;
   logic                 wr_txbuf;
   logic                 wr_imask;
   logic                 wr_istat;
   logic                 wb_ack_d;
   logic [31:0]          wb_dat_d;
   logic                 mp_mode_q, mp_mode_d;
   logic                 soft_rst_n_q, soft_rst_n_d;
   logic                 tx_wake_q, tx_wake_d;
   logic                 wut_q, wut_d;
   logic [7:0]           txbuf_q, txbuf_d;
   logic                 txbuf_full_q, txbuf_full_d;
   logic [7:0]           shreg_q, shreg_d;
   logic [3:0]           bitcnt_q, bitcnt_d;
   logic [CW-1:0]        baud_q, baud_d;
   logic                 bit_tick;
   logic                 tx_done;
   logic                 tx_line_d;
   logic                 tx_empty_q, tx_empty_d;
   usw_tx_state_e        tx_state_q, tx_state_d;
   logic [6:0]           rxst_q, rxst_d;
   logic [IRQ_W-1:0]     ist_q, ist_d;
   logic [IRQ_W-1:0]     imask_q, imask_d;
   logic [IRQ_W-1:0]     ev;
   logic                 irq_d;

   assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr       = req & wb_we_i & wb_sel_i[0];
   assign wr_ccr   = wr & hit(wb_adr_i, OFF_COMM_CTRL);
   assign wr_ctl1  = wr & hit(wb_adr_i, OFF_CTRL_ONE);
   assign wr_txbuf = wr & hit(wb_adr_i, OFF_TX_BUFFER);
   assign wr_imask = wr & hit(wb_adr_i, OFF_IRQ_MASK);
   assign wr_istat = wr & hit(wb_adr_i, OFF_IRQ_STATUS);
   assign bit_tick = (baud_q == TICK_LAST);

   // Bus slave: one wait state, unmapped reads give zero, writes dropped
   always_comb
   begin
      wb_ack_d  = req;
      wb_dat_d  = 32'h0;
      mp_mode_d = mp_mode_q;
      soft_rst_n_d = soft_rst_n_q;
      if (wr_ccr)
         mp_mode_d = wb_dat_i[MP_MODE_BIT];
      if (wr_ctl1)
         soft_rst_n_d = wb_dat_i[SOFT_RST_BIT];
      if (req & ~wb_we_i)
      begin
         if (hit(wb_adr_i, OFF_COMM_CTRL))
            wb_dat_d[MP_MODE_BIT] = mp_mode_q;
         if (hit(wb_adr_i, OFF_CTRL_ONE))
         begin
            wb_dat_d[SOFT_RST_BIT] = soft_rst_n_q;
            wb_dat_d[TX_WAKE_BIT]  = tx_wake_q;
            wb_dat_d[RESERVED_BIT] = 1'b0;
         end
         if (hit(wb_adr_i, OFF_CTRL_TWO))
         begin
            wb_dat_d[TX_RDY_BIT]   = ~txbuf_full_q;
            wb_dat_d[TX_EMPTY_BIT] = tx_empty_q;
         end
         if (hit(wb_adr_i, OFF_RX_STATUS))
            wb_dat_d[7:1] = rxst_q;
         if (hit(wb_adr_i, OFF_IRQ_STATUS))
            wb_dat_d[IRQ_W-1:0] = ist_q;
         if (hit(wb_adr_i, OFF_IRQ_MASK))
            wb_dat_d[IRQ_W-1:0] = imask_q;
      end
   end

   // Soft reset leaves mode and mask untouched; only system reset does that
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wb_ack_o     <= 1'b0;
         wb_dat_o     <= 32'h0;
         mp_mode_q    <= 1'b0;
         soft_rst_n_q <= 1'b0;
      end
      else
      begin
         wb_ack_o     <= wb_ack_d;
         wb_dat_o     <= wb_dat_d;
         mp_mode_q    <= mp_mode_d;
         soft_rst_n_q <= soft_rst_n_d;
      end
   end

   // Transmitter; a buffer write during soft reset is discarded
   always_comb
   begin
      tx_state_d   = tx_state_q;
      tx_wake_d    = tx_wake_q;
      wut_d        = wut_q;
      txbuf_d      = txbuf_q;
      txbuf_full_d = txbuf_full_q;
      shreg_d      = shreg_q;
      bitcnt_d     = bitcnt_q;
      baud_d       = bit_tick ? '0 : baud_q + CW'(1);
      tx_done      = 1'b0;
      if (!soft_rst_n_q)
      begin
         tx_state_d   = TX_IDLE;
         txbuf_full_d = 1'b0;
         wut_d        = 1'b0;
         baud_d       = '0;
      end
      else
      begin
         case (tx_state_q)
            TX_IDLE:
            begin
               baud_d = '0;
               if (txbuf_full_q)
               begin
                  shreg_d      = txbuf_q;
                  txbuf_full_d = 1'b0;
                  wut_d        = tx_wake_q;
                  tx_wake_d    = 1'b0;
                  bitcnt_d     = 4'h0;
                  // Idle gap only in idle-line mode
                  tx_state_d = (tx_wake_q && !mp_mode_q) ? TX_GAP
                                                         : TX_START;
               end
            end
            TX_GAP:
               if (bit_tick)
               begin
                  bitcnt_d = bitcnt_q + 4'h1;
                  if (bitcnt_q == IDLE_BITS - 4'h1)
                  begin
                     bitcnt_d   = 4'h0;
                     tx_state_d = TX_START;
                  end
               end
            TX_START:
               if (bit_tick)
                  tx_state_d = TX_DATA;
            TX_DATA:
               if (bit_tick)
               begin
                  shreg_d  = {1'b0, shreg_q[7:1]};
                  bitcnt_d = bitcnt_q + 4'h1;
                  if (bitcnt_q == LAST_DATA_BIT)
                  begin
                     bitcnt_d   = 4'h0;
                     tx_state_d = mp_mode_q ? TX_ADDR : TX_STOP;
                  end
               end
            TX_ADDR:
               if (bit_tick)
                  tx_state_d = TX_STOP;
            TX_STOP:
               if (bit_tick)
               begin
                  tx_state_d = TX_IDLE;
                  tx_done    = 1'b1;
               end
            default:
               tx_state_d = TX_IDLE;
         endcase
         if (wr_txbuf)
         begin
            txbuf_d      = wb_dat_i[7:0];
            txbuf_full_d = 1'b1;
         end
      end
      // A software write to the wake bit beats the clear on transfer
      if (wr_ctl1)
         tx_wake_d = wb_dat_i[TX_WAKE_BIT];
      case (tx_state_d)
         TX_START: tx_line_d = 1'b0;
         TX_DATA:  tx_line_d = shreg_d[0];
         TX_ADDR:  tx_line_d = wut_d;
         default:  tx_line_d = 1'b1;
      endcase
      tx_empty_d = soft_rst_n_q & ~txbuf_full_d & (tx_state_d == TX_IDLE);
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         tx_state_q   <= TX_IDLE;
         tx_wake_q    <= 1'b0;
         wut_q        <= 1'b0;
         txbuf_q      <= TX_BUF_RST;
         txbuf_full_q <= 1'b0;
         shreg_q      <= TX_BUF_RST;
         bitcnt_q     <= 4'h0;
         baud_q       <= '0;
         tx_line_o    <= 1'b1;
         tx_empty_q   <= 1'b0;
      end
      else
      begin
         tx_state_q   <= tx_state_d;
         tx_wake_q    <= tx_wake_d;
         wut_q        <= wut_d;
         txbuf_q      <= txbuf_d;
         txbuf_full_q <= txbuf_full_d;
         shreg_q      <= shreg_d;
         bitcnt_q     <= bitcnt_d;
         baud_q       <= baud_d;
         tx_line_o    <= tx_line_d;
         tx_empty_q   <= tx_empty_d;
      end
   end

   // Receive flags and interrupts; bit 7 of the status is the error summary
   always_comb
   begin
      rxst_d = rxst_q | {1'b0, rx_ready_evt, rx_break_evt, rx_framing_evt,
                         rx_overrun_evt, rx_parity_evt, rx_wake_evt};
      rxst_d[RX_ERR_BIT-1] = |rxst_d[4:1];
      if (!soft_rst_n_q)
         rxst_d = RX_FLAGS_RST;
      ev = '0;
      ev[IRQ_TX_DONE]  = tx_done;
      ev[IRQ_RX_READY] = rx_ready_evt & soft_rst_n_q;
      ev[IRQ_RX_ERROR] = soft_rst_n_q & (rx_parity_evt | rx_overrun_evt |
                                         rx_framing_evt | rx_break_evt);
      ist_d = ist_q;
      if (wr_istat)
         ist_d = ist_q & ~wb_dat_i[IRQ_W-1:0];
      ist_d   = ist_d | ev;
      imask_d = wr_imask ? wb_dat_i[IRQ_W-1:0] : imask_q;
      irq_d   = |(ist_d & imask_d);
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rxst_q  <= RX_FLAGS_RST;
         ist_q   <= IRQ_RST;
         imask_q <= IRQ_RST;
         irq_o   <= 1'b0;
      end
      else
      begin
         rxst_q  <= rxst_d;
         ist_q   <= ist_d;
         imask_q <= imask_d;
         irq_o   <= irq_d;
      end
   end

   a_soft_rst_idle: assert property (@(posedge clk) disable iff (reset)
      !soft_rst_n_q |=> tx_state_q == TX_IDLE && tx_line_o && !txbuf_full_q)
      else $error("state machine not held idle in soft reset");
   a_soft_rst_flags: assert property (@(posedge clk) disable iff (reset)
      !soft_rst_n_q |=> rxst_q == 7'h00 && !tx_empty_q)
      else $error("receive flags not cleared in soft reset");
   a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
      (wb_cyc_i && !wb_we_i && hit(wb_adr_i, OFF_CTRL_ONE) && wb_ack_o)
      |-> !wb_dat_o[RESERVED_BIT])
      else $error("reserved bit read as one");
   a_wake_keep: assert property (@(posedge clk) disable iff (reset)
      (!soft_rst_n_q && !wr_ctl1) |=> tx_wake_q == $past(tx_wake_q))
      else $error("wake selector changed by soft reset");
   a_wake_copy: assert property (@(posedge clk) disable iff (reset)
      (tx_state_q == TX_IDLE && txbuf_full_q && soft_rst_n_q && !wr_ctl1)
      |=> wut_q == $past(tx_wake_q) && !tx_wake_q)
      else $error("wake selector not moved into temp flag");
   a_idle_gap: assert property (@(posedge clk) disable iff (reset)
      (tx_state_q == TX_IDLE && txbuf_full_q && soft_rst_n_q && tx_wake_q
       && !mp_mode_q) |=> tx_state_q == TX_GAP ##1 tx_line_o [*8])
      else $error("idle gap missing before woken frame");
   a_addr_bit: assert property (@(posedge clk) disable iff (reset)
      $rose(tx_state_q == TX_ADDR) |-> tx_line_o == wut_q)
      else $error("address bit does not follow temp flag");
   a_mode_select: assert property (@(posedge clk) disable iff (reset)
      (tx_state_q == TX_DATA && bit_tick && bitcnt_q == LAST_DATA_BIT
       && soft_rst_n_q)
      |=> tx_state_q == ($past(mp_mode_q) ? TX_ADDR : TX_STOP))
      else $error("frame tail ignores mode bit");
   a_no_gap_addr: assert property (@(posedge clk) disable iff (reset)
      (tx_state_q == TX_IDLE && txbuf_full_q && soft_rst_n_q && mp_mode_q)
      |=> tx_state_q == TX_START)
      else $error("idle gap sent in address-bit mode");
   a_cfg_keep: assert property (@(posedge clk) disable iff (reset)
      (!soft_rst_n_q && !wr_ccr && !wr_imask)
      |=> mp_mode_q == $past(mp_mode_q) && imask_q == $past(imask_q))
      else $error("configuration changed by soft reset");
endmodule

// ===== shared/usw_pkg.sv
// Register map, field positions, reset values and states of the serial port
package usw_pkg;
   localparam int          ADR_W          = 8;
   localparam logic [7:0]  OFF_COMM_CTRL  = 8'h00;
   localparam logic [7:0]  OFF_CTRL_ONE   = 8'h04;
   localparam logic [7:0]  OFF_CTRL_TWO   = 8'h08;
   localparam logic [7:0]  OFF_RX_STATUS  = 8'h0c;
   localparam logic [7:0]  OFF_TX_BUFFER  = 8'h10;
   localparam logic [7:0]  OFF_IRQ_STATUS = 8'h14;
   localparam logic [7:0]  OFF_IRQ_MASK   = 8'h18;
   // Field positions
   localparam int          MP_MODE_BIT    = 3;
   localparam int          SOFT_RST_BIT   = 5;
   localparam int          RESERVED_BIT   = 4;
   localparam int          TX_WAKE_BIT    = 3;
   localparam int          TX_RDY_BIT     = 7;
   localparam int          TX_EMPTY_BIT   = 6;
   localparam int          RX_ERR_BIT     = 7;
   // Interrupt status layout
   localparam int          IRQ_W          = 3;
   localparam int          IRQ_TX_DONE    = 0;
   localparam int          IRQ_RX_READY   = 1;
   localparam int          IRQ_RX_ERROR   = 2;
   // Values after reset
   localparam logic [6:0]  RX_FLAGS_RST   = 7'h00;
   localparam logic [2:0]  IRQ_RST        = 3'h0;
   localparam logic [7:0]  TX_BUF_RST     = 8'h00;
   // Timing
   localparam int          BIT_CYCLES_DEF = 16;
   localparam logic [3:0]  IDLE_BITS      = 4'hb;
   localparam logic [3:0]  LAST_DATA_BIT  = 4'h7;
   typedef enum logic [2:0] {
      TX_IDLE, TX_GAP, TX_START, TX_DATA, TX_ADDR, TX_STOP
   } usw_tx_state_e;
endpackage

// ===== verification/usw_line_node.sv
// Remote node model: decodes frames seen on the transmit line
`timescale 1ns/1ps
module usw_line_node
#(
   parameter int BC = 4
)(
   input  wire logic       clk,
   input  wire logic       line,
   input  wire logic       addr_mode,
   output logic [7:0]      data,
   output logic            addr,
   output logic            stop_ok,
   output int              frames
);
   logic [7:0] d;
   initial
   begin
      frames = 0;
      data = 8'h00;
      addr = 1'h0;
      stop_ok = 1'h0;
      forever
      begin
         @(negedge line);
         // Sample mid-bit so a late edge on the line is tolerated
         repeat (BC / 2) @(posedge clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BC) @(posedge clk);
            d[i] = line;
         end
         addr = 1'h0;
         if (addr_mode)
         begin
            repeat (BC) @(posedge clk);
            addr = line;
         end
         repeat (BC) @(posedge clk);
         stop_ok = line;
         data = d;
         frames++;
      end
   end
endmodule

// ===== verification/test_usw_serial_port.sv
// Testbench of the serial port control block
`timescale 1ns/1ps
module test_usw_serial_port;
   import usw_pkg::*;
   localparam int BC = 4;
   logic        clk   = 1'h0;
   logic        reset = 1'h1;
   logic        cyc   = 1'h0;
   logic        stb   = 1'h0;
   logic        we    = 1'h0;
   logic [7:0]  adr   = 8'h00;
   logic [3:0]  sel   = 4'hf;
   logic [31:0] wdat  = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic [5:0]  evt   = 6'h00;
   logic        line;
   logic        irq;
   logic        mode  = 1'h0;
   logic [7:0]  rd;
   logic [7:0]  pdata;
   logic        paddr;
   logic        pstop;
   int          frames;
   int          n;
   int          mismatches = 0;
   int          checked = 0;

   always #5 clk = ~clk;

   usw_serial_port #(.BIT_CYCLES(BC)) u_usw_serial_port (
      .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .rx_wake_evt(evt[0]),
      .rx_parity_evt(evt[1]), .rx_overrun_evt(evt[2]),
      .rx_framing_evt(evt[3]), .rx_break_evt(evt[4]),
      .rx_ready_evt(evt[5]), .tx_line_o(line), .irq_o(irq));

   usw_line_node #(.BC(BC)) u_usw_line_node (
      .clk(clk), .line(line), .addr_mode(mode), .data(pdata),
      .addr(paddr), .stop_ok(pstop), .frames(frames));

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Classic cycle: request held until ack is seen at a rising edge;
   // read data is taken at that edge and the request released after it
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [7:0] dv);
      n = 0;
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, dv};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'h1 && n < 100);
      rd = rdat[7:0];
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      check("bus answer", n < 100, 1'h1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] dv);
      wb(1'h1, a, dv);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [7:0] exp);
      wb(1'h0, a, 8'h00);
      check(nm, rd, exp);
   endtask

   task automatic pulse(input logic [5:0] m);
      @(posedge clk);
      evt <= m;
      @(posedge clk);
      evt <= 6'h00;
      repeat (3) @(posedge clk);
   endtask

   task automatic wait_start();
      n = 0;
      while (line !== 1'h0 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      // A line stuck high must not pass as a long idle gap
      check("start bit", line, 1'h0);
   endtask

   task automatic wait_frames(input int k);
      n = 0;
      while (frames < k && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      check("frames", frames, k);
      check("stop bit", pstop, 1'h1);
   endtask

   task automatic finish_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      finish_test();
   end

   initial
   begin
      repeat (5) @(posedge clk);
      reset <= 1'h0;
      rd_chk("ctl one", OFF_CTRL_ONE, 8'h00);
      rd_chk("ctl two", OFF_CTRL_TWO, 8'h80);
      // Port still held: this byte must never reach the line
      wr(OFF_TX_BUFFER, 8'h11);
      pulse(6'h3f);
      rd_chk("rx frozen", OFF_RX_STATUS, 8'h00);
      wr(OFF_CTRL_ONE, 8'h38);
      rd_chk("ctl one rsv", OFF_CTRL_ONE, 8'h28);
      check("held frame", frames, 0);
      rd_chk("unmapped", 8'h1c, 8'h00);
      pulse(6'h38);
      rd_chk("rx flags", OFF_RX_STATUS, 8'hf0);
      rd_chk("irq status", OFF_IRQ_STATUS, 8'h06);
      wr(OFF_IRQ_MASK, 8'h06);
      repeat (2) @(posedge clk);
      check("irq on", irq, 1'h1);
      wr(OFF_IRQ_MASK, 8'h00);
      repeat (2) @(posedge clk);
      check("irq masked", irq, 1'h0);
      wr(OFF_IRQ_STATUS, 8'h06);
      rd_chk("irq cleared", OFF_IRQ_STATUS, 8'h00);
      wr(OFF_COMM_CTRL, 8'h08);
      wr(OFF_CTRL_ONE, 8'h08);
      rd_chk("rx soft", OFF_RX_STATUS, 8'h00);
      rd_chk("wake kept", OFF_CTRL_ONE, 8'h08);
      rd_chk("mode kept", OFF_COMM_CTRL, 8'h08);
      // Idle-line mode: wake set asks for a gap before the frame
      wr(OFF_COMM_CTRL, 8'h00);
      wr(OFF_CTRL_ONE, 8'h28);
      wr(OFF_IRQ_MASK, 8'h01);
      wr(OFF_TX_BUFFER, 8'ha5);
      wait_start();
      check("idle gap", n >= 11 * BC, 1'h1);
      rd_chk("wake clear", OFF_CTRL_ONE, 8'h20);
      wait_frames(1);
      check("data gap", pdata, 8'ha5);
      repeat (BC + 2) @(posedge clk);
      check("irq done", irq, 1'h1);
      wr(OFF_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge clk);
      check("irq done clr", irq, 1'h0);
      wr(OFF_TX_BUFFER, 8'h3c);
      wait_start();
      check("no gap", n < 2 * BC, 1'h1);
      wait_frames(2);
      check("data plain", pdata, 8'h3c);
      // Address-bit mode: wake marks exactly the next frame
      wr(OFF_COMM_CTRL, 8'h08);
      mode = 1'h1;
      wr(OFF_CTRL_ONE, 8'h28);
      wr(OFF_TX_BUFFER, 8'h5a);
      wait_frames(3);
      check("addr data", pdata, 8'h5a);
      check("addr set", paddr, 1'h1);
      wr(OFF_TX_BUFFER, 8'h81);
      wait_frames(4);
      check("plain data", pdata, 8'h81);
      check("addr clear", paddr, 1'h0);
      check("irq frames", irq, 1'h1);
      repeat (BC) @(posedge clk);
      rd_chk("tx empty", OFF_CTRL_TWO, 8'hc0);
      finish_test();
   end
endmodule
